/* File: verilog/sadc_params.svh */
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// register byte offsets on the AXI4-Lite slave
`define SADC_ADDR_W        5
`define SADC_WORD_MASK     5'h1C
`define SADC_OFS_CTRL      5'h00
`define SADC_OFS_CFG       5'h04
`define SADC_OFS_RESULT    5'h08
`define SADC_OFS_IRQ_STAT  5'h0C
`define SADC_OFS_IRQ_MASK  5'h10

// converter_control_reg fields
`define SADC_CTRL_STM_LO   0
`define SADC_CTRL_STM_HI   1
`define SADC_CTRL_TM       2
`define SADC_CTRL_BUSY     3
`define SADC_CTRL_DONE     4

// converter_config_reg fields
`define SADC_CFG_DIV_LSB   0
`define SADC_CFG_DIV_MSB   2
`define SADC_DIV_SEL_MAX   3'h4

// status and mask layout
`define SADC_IRQ_DONE      0

// reset values
`define SADC_CTRL_RST      5'h00
`define SADC_DIV_RST       3'h0
`define SADC_RESULT_RST    8'h00

// timing in converter clocks
`define SADC_TRACK_CLKS    5'h03
`define SADC_CONV_CLKS     5'h10

// bus responses
`define SADC_RESP_OKAY     2'h0
`define SADC_RESP_SLVERR   2'h2

`endif

/* File: verilog/sadc_pkg.sv */
package sadc_pkg;

   typedef enum logic [1:0] {
      SADC_IDLE  = 2'h0,
      SADC_TRACK = 2'h1,
      SADC_CONV  = 2'h2
   } sadc_state_t;

   typedef enum logic [1:0] {
      SADC_START_SW   = 2'h0,
      SADC_START_TMR  = 2'h1,
      SADC_START_SW2  = 2'h2,
      SADC_START_SW3  = 2'h3
   } sadc_start_t;

endpackage : sadc_pkg

/* File: verilog/sadc_clkdiv.sv */
`include "sadc_params.svh"

module sadc_clkdiv
   import sadc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] div_sel_i,
   output logic            tick_o
);

   logic [3:0] cnt;
   logic [3:0] limit;

   // codes above the largest ratio clamp to divide by 16
   always_comb begin
      unique case (div_sel_i)
         3'h0:    limit = 4'h0;
         3'h1:    limit = 4'h1;
         3'h2:    limit = 4'h3;
         3'h3:    limit = 4'h7;
         default: limit = 4'hF;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
      end else if (cnt >= limit) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt >= limit);
      end
   end

endmodule : sadc_clkdiv

/* File: verilog/sadc_ctrl.sv */
// Notes on behaviour
// - the converter clock is the system clock divided by 1, 2, 4, 8 or 16 per the config divider field.
// - the two start mode bits choose software start or timer overflow start.
// - in software start mode a 1 written to the busy bit begins a conversion.
// - in timed start mode each timer 2 overflow that arrives while busy is 0 begins a conversion; one during a conversion is dropped.
// - the busy bit reads 1 during a conversion and returns to 0 when it completes.
// - the fall of busy sets the done flag and raises the interrupt when enabled.
// - at completion the converted value is placed in the result register.
// - with track mode 0 the input is tracked at all times except during conversion.
// - with track mode 1 and software start, tracking begins on the busy write for 3 clocks.
// - with track mode 1 and timer start, tracking begins on the overflow for 3 clocks.
// - tracking is shut down while the chip is in standby or sleep.
// - each conversion takes 16 converter clocks after tracking.
`include "sadc_params.svh"

module sadc_ctrl
   import sadc_pkg::*;
(
   input  wire logic                    SYS_CLK_I,
   input  wire logic                    RESET_I,
   input  wire logic                    TIMER2_OVF_I,
   input  wire logic                    STANDBY_I,
   input  wire logic                    COMP_I,
   output logic                         TRACK_O,
   output logic                         CONV_CLK_TICK_O,
   output logic [7:0]                   DAC_CODE_O,
   output logic                         IRQ_O,
   input  wire logic [`SADC_ADDR_W-1:0] AWADDR_I,
   input  wire logic                    AWVALID_I,
   output logic                         AWREADY_O,
   input  wire logic [31:0]             WDATA_I,
   input  wire logic [3:0]              WSTRB_I,
   input  wire logic                    WVALID_I,
   output logic                         WREADY_O,
   output logic [1:0]                   BRESP_O,
   output logic                         BVALID_O,
   input  wire logic                    BREADY_I,
   input  wire logic [`SADC_ADDR_W-1:0] ARADDR_I,
   input  wire logic                    ARVALID_I,
   output logic                         ARREADY_O,
   output logic [31:0]                  RDATA_O,
   output logic [1:0]                   RRESP_O,
   output logic                         RVALID_O,
   input  wire logic                    RREADY_I
);

   // pin synchronisers
   logic [1:0]              comp_sync;
   logic [1:0]              standby_sync;
   logic                    comp_s;
   logic                    standby_s;

   // bus state
   logic                    aw_held;
   logic                    w_held;
   logic [`SADC_ADDR_W-1:0] aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    wr_fire;
   logic                    rd_fire;
   logic [`SADC_ADDR_W-1:0] wr_word;
   logic [`SADC_ADDR_W-1:0] rd_word;
   logic                    wr_mapped;
   logic                    rd_mapped;
   logic                    wr_ctrl;
   logic                    wr_cfg;
   logic                    wr_mask;
   logic                    rd_stat;
   logic [31:0]             next_rdata;

   // control and status
   sadc_start_t             start_mode;
   logic                    track_mode;
   logic [2:0]              div_sel;
   logic                    busy;
   logic                    done_flag;
   logic                    irq_stat;
   logic                    irq_mask;
   logic [7:0]              result;
   logic                    sw_start;
   logic                    tmr_start;
   logic                    start;
   logic                    conv_end;
   logic                    next_irq_stat;

   // sequencer
   sadc_state_t             state;
   logic [4:0]              cnt;
   logic [7:0]              code;
   logic [7:0]              next_code;
   logic [2:0]              bit_idx;
   logic                    tick;

   sadc_clkdiv u_clkdiv (
      .clk_i     (SYS_CLK_I),
      .rst_i     (RESET_I),
      .div_sel_i (div_sel),
      .tick_o    (tick)
   );

   // the comparator and standby pins are asynchronous to the bus clock
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         comp_sync    <= 2'h0;
         standby_sync <= 2'h0;
      end else begin
         comp_sync    <= {comp_sync[0], COMP_I};
         standby_sync <= {standby_sync[0], STANDBY_I};
      end
   end

   assign comp_s    = comp_sync[1];
   assign standby_s = standby_sync[1];

   // ---------------- write channel ----------------
   assign AWREADY_O = !aw_held && !BVALID_O;
   assign WREADY_O  = !w_held && !BVALID_O;
   assign wr_fire   = aw_held && w_held && !BVALID_O;
   assign wr_word   = aw_addr & `SADC_WORD_MASK;
   assign wr_ctrl   = wr_fire && (wr_word == `SADC_OFS_CTRL) && w_strb[0];
   assign wr_cfg    = wr_fire && (wr_word == `SADC_OFS_CFG) && w_strb[0];
   assign wr_mask   = wr_fire && (wr_word == `SADC_OFS_IRQ_MASK) && w_strb[0];

   always_comb begin
      unique case (wr_word)
         `SADC_OFS_CTRL,
         `SADC_OFS_CFG,
         `SADC_OFS_RESULT,
         `SADC_OFS_IRQ_STAT,
         `SADC_OFS_IRQ_MASK: wr_mapped = 1'b1;
         default:            wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (AWVALID_I && AWREADY_O) begin
         aw_held <= 1'b1;
         aw_addr <= AWADDR_I;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (WVALID_I && WREADY_O) begin
         w_held <= 1'b1;
         w_data <= WDATA_I;
         w_strb <= WSTRB_I;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         BVALID_O <= 1'b0;
         BRESP_O  <= `SADC_RESP_OKAY;
      end else if (wr_fire) begin
         BVALID_O <= 1'b1;
         BRESP_O  <= wr_mapped ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
      end else if (BREADY_I) begin
         BVALID_O <= 1'b0;
      end
   end

   // ---------------- read channel ----------------
   assign ARREADY_O = !RVALID_O;
   assign rd_fire   = ARVALID_I && ARREADY_O;
   assign rd_word   = ARADDR_I & `SADC_WORD_MASK;
   assign rd_stat   = rd_fire && (rd_word == `SADC_OFS_IRQ_STAT);

   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_mapped  = 1'b1;
      unique case (rd_word)
         `SADC_OFS_CTRL: begin
            next_rdata[`SADC_CTRL_STM_HI:`SADC_CTRL_STM_LO] = start_mode;
            next_rdata[`SADC_CTRL_TM]   = track_mode;
            next_rdata[`SADC_CTRL_BUSY] = busy;
            next_rdata[`SADC_CTRL_DONE] = done_flag;
         end
         `SADC_OFS_CFG: begin
            next_rdata[`SADC_CFG_DIV_MSB:`SADC_CFG_DIV_LSB] = div_sel;
         end
         `SADC_OFS_RESULT: begin
            next_rdata[7:0] = result;
         end
         `SADC_OFS_IRQ_STAT: begin
            next_rdata[`SADC_IRQ_DONE] = irq_stat;
         end
         `SADC_OFS_IRQ_MASK: begin
            next_rdata[`SADC_IRQ_DONE] = irq_mask;
         end
         default: begin
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         RVALID_O <= 1'b0;
         RDATA_O  <= 32'h0000_0000;
         RRESP_O  <= `SADC_RESP_OKAY;
      end else if (rd_fire) begin
         RVALID_O <= 1'b1;
         RDATA_O  <= next_rdata;
         RRESP_O  <= rd_mapped ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
      end else if (RREADY_I) begin
         RVALID_O <= 1'b0;
      end
   end

   // ---------------- configuration ----------------
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         start_mode <= SADC_START_SW;
         track_mode <= 1'b0;
      end else if (wr_ctrl) begin
         start_mode <= sadc_start_t'(w_data[`SADC_CTRL_STM_HI:`SADC_CTRL_STM_LO]);
         track_mode <= w_data[`SADC_CTRL_TM];
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         div_sel <= `SADC_DIV_RST;
      end else if (wr_cfg) begin
         div_sel <= w_data[`SADC_CFG_DIV_MSB:`SADC_CFG_DIV_LSB];
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irq_mask <= 1'b0;
      end else if (wr_mask) begin
         irq_mask <= w_data[`SADC_IRQ_DONE];
      end
   end

   // ---------------- start and busy ----------------
   // only the timer code selects overflow starts; the other codes are software
   assign sw_start  = wr_ctrl && w_data[`SADC_CTRL_BUSY]
                      && (start_mode != SADC_START_TMR);
   assign tmr_start = TIMER2_OVF_I && (start_mode == SADC_START_TMR);
   // a start while busy is dropped, a running conversion is never restarted
   assign start     = !busy && (sw_start || tmr_start);
   assign conv_end  = (state == SADC_CONV) && tick && (cnt == `SADC_CONV_CLKS - 5'h01);

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         busy <= 1'b0;
      end else if (start) begin
         busy <= 1'b1;
      end else if (conv_end) begin
         busy <= 1'b0;
      end
   end

   // done flag: a clearing write loses against a finishing conversion
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         done_flag <= 1'b0;
      end else if (conv_end) begin
         done_flag <= 1'b1;
      end else if (wr_ctrl && !w_data[`SADC_CTRL_DONE]) begin
         done_flag <= 1'b0;
      end
   end

   // sticky status, cleared by a read, set wins
   always_comb begin
      next_irq_stat = irq_stat;
      if (rd_stat) begin
         next_irq_stat = 1'b0;
      end
      if (conv_end) begin
         next_irq_stat = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irq_stat <= 1'b0;
         IRQ_O    <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         IRQ_O    <= next_irq_stat && irq_mask;
      end
   end

   // ---------------- sequencer ----------------
   // two converter clocks per bit: one to set the trial, one to decide
   assign bit_idx = 3'h7 - cnt[3:1];

   always_comb begin
      next_code = code;
      if (!cnt[0]) begin
         next_code[bit_idx] = 1'b1;
      end else begin
         next_code[bit_idx] = comp_s;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state <= SADC_IDLE;
         cnt   <= 5'h00;
         code  <= 8'h00;
      end else begin
         unique case (state)
            SADC_IDLE: begin
               if (busy && tick) begin
                  cnt  <= 5'h00;
                  code <= 8'h00;
                  state <= track_mode ? SADC_TRACK : SADC_CONV;
               end
            end
            SADC_TRACK: begin
               if (tick) begin
                  if (cnt == `SADC_TRACK_CLKS - 5'h01) begin
                     cnt   <= 5'h00;
                     state <= SADC_CONV;
                  end else begin
                     cnt <= cnt + 5'h01;
                  end
               end
            end
            SADC_CONV: begin
               if (tick) begin
                  code <= next_code;
                  if (cnt == `SADC_CONV_CLKS - 5'h01) begin
                     cnt   <= 5'h00;
                     state <= SADC_IDLE;
                  end else begin
                     cnt <= cnt + 5'h01;
                  end
               end
            end
            default: begin
               state <= SADC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         result <= `SADC_RESULT_RST;
      end else if (conv_end) begin
         result <= next_code;
      end
   end

   // ---------------- converter pins ----------------
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         TRACK_O <= 1'b0;
      end else if (standby_s) begin
         TRACK_O <= 1'b0;
      end else if (track_mode) begin
         TRACK_O <= (state == SADC_TRACK);
      end else begin
         TRACK_O <= (state != SADC_CONV);
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         DAC_CODE_O      <= 8'h00;
         CONV_CLK_TICK_O <= 1'b0;
      end else begin
         DAC_CODE_O      <= code;
         CONV_CLK_TICK_O <= tick;
      end
   end

endmodule : sadc_ctrl

/* File: tb/sadc_front_model.sv */
module sadc_front_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] dac_code_i,
   input  wire logic [7:0] level_i,
   input  wire logic       fire_i,
   output logic            comp_o,
   output logic            ovf_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic fire_q = 1'b0;
   // ties resolve to 1 so the search lands on the level itself, not one below
   assign comp_o = (level_i >= dac_code_i);
   // one-cycle overflow pulse per request, as a real timer gives
   always @(posedge clk_i) begin
      fire_q <= fire_i;
      ovf_o <= fire_i & ~fire_q;
   end
endmodule : sadc_front_model

/* File: tb/sadc_ctrl_props.sv */
`include "sadc_params.svh"

module sadc_ctrl_props (
   input wire logic        SYS_CLK_I,
   input wire logic        RESET_I,
   input wire logic        STANDBY_I,
   input wire logic        TRACK_O,
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic [1:0]  BRESP_O,
   input wire logic        BVALID_O,
   input wire logic        BREADY_I,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic [1:0]  RRESP_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RESET_I);
   // the pair is held one edge, then the response register loads on the next
   property p_wr_answer;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("no write response");
   property p_b_hold;
      BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_aw_block;
      BVALID_O |-> !AWREADY_O && !WREADY_O;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken early");
   property p_resp;
      BVALID_O |-> BRESP_O == `SADC_RESP_OKAY || BRESP_O == `SADC_RESP_SLVERR;
   endproperty
   a_resp: assert property (p_resp) else $error("bad write response");
   property p_rd_answer;
      ARVALID_I && ARREADY_O |=> RVALID_O;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read data");
   property p_r_hold;
      RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_block;
      RVALID_O |-> !ARREADY_O;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken early");
   // two sync stages plus the output register
   property p_standby;
      STANDBY_I [*4] |-> !TRACK_O;
   endproperty
   a_standby: assert property (p_standby) else $error("tracking in standby");
endmodule : sadc_ctrl_props
bind sadc_ctrl sadc_ctrl_props sadc_ctrl_props_inst (
   .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .STANDBY_I(STANDBY_I), .TRACK_O(TRACK_O),
   .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
   .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
   .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
   .RREADY_I(RREADY_I)
);

/* File: tb/sadc_ctrl_bench.sv */
`include "sadc_params.svh"

module sadc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] ctl = `SADC_OFS_CTRL, cfg = `SADC_OFS_CFG;
   localparam logic [4:0] res = `SADC_OFS_RESULT, sta = `SADC_OFS_IRQ_STAT;
   logic clk = 1'b0, rst = 1'b1, stby = 1'b0, fire = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] level = 8'h00;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic ovf, comp, trk, tick, irq, awready, wready, bvalid, arready, rvalid;
   logic [7:0] dac;
   logic [1:0] bresp, rresp, resp;
   int err_count = 0, compares = 0, hi_n = 0, lo_n = 0, hi_len = 0, lo_len = 0;

   always #2 clk = ~clk;

   sadc_ctrl sadc_ctrl_inst (
      .SYS_CLK_I(clk), .RESET_I(rst), .TIMER2_OVF_I(ovf), .STANDBY_I(stby), .COMP_I(comp),
      .TRACK_O(trk), .CONV_CLK_TICK_O(tick), .DAC_CODE_O(dac), .IRQ_O(irq),
      .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready)
   );

   sadc_front_model sadc_front_model_inst (
      .clk_i(clk), .dac_code_i(dac), .level_i(level), .fire_i(fire), .comp_o(comp), .ovf_o(ovf)
   );

   // run lengths of the track output, latched when it turns
   always @(negedge clk) begin
      if (trk === 1'b1) begin
         if (lo_n != 0) lo_len = lo_n;
         lo_n = 0;
         hi_n++;
      end else begin
         if (hi_n != 0) hi_len = hi_n;
         hi_n = 0;
         lo_n++;
      end
   end

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %0s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // readiness is looked at on the falling edge so the rising edge decides without a race
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic ga, gw, ta, tw;
      ga = 1'b0;
      gw = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // no cycle count is assumed here; only the watchdog ends a hung wait
      while (!(ga && gw)) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         ga = ga | ta;
         gw = gw | tw;
      end
      while (bvalid !== 1'b1) begin
         @(negedge clk);
      end
      @(posedge clk);
      bready <= 1'b1;
      @(negedge clk);
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [4:0] a);
      logic t;
      t = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      while (!t) begin
         @(negedge clk);
         t = arvalid && arready;
         @(posedge clk);
         if (t) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1) begin
         @(negedge clk);
      end
      @(posedge clk);
      rready <= 1'b1;
      @(negedge clk);
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : rdr

   task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
      rdr(a);
      check(what, rd, exp);
      check("read response", resp, `SADC_RESP_OKAY);
   endtask : rchk

   task automatic gap(output int g);
      g = 0;
      do begin
         @(negedge clk);
         g++;
      end while (tick !== 1'b1 && g < 40);
   endtask : gap

   task automatic pulse();
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (4) @(negedge clk);
   endtask : pulse

   // software waits on the done flag, never on busy
   task automatic conv_end(input logic [7:0] r, input logic [31:0] c, input logic i);
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[`SADC_CTRL_DONE] !== 1'b1 && n < 200) begin
         rdr(ctl);
         n++;
      end
      check("ctrl at end", rd, c);
      @(negedge clk);
      check("irq line", irq, i);
      rchk("result", res, r);
      rchk("status set", sta, 32'h1);
      rchk("status cleared", sta, 32'h0);
      @(negedge clk);
      check("irq released", irq, 1'b0);
   endtask : conv_end

   initial begin
      int g;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rchk("ctrl reset", ctl, 32'h0);
      rchk("cfg reset", cfg, 32'h0);
      rchk("result reset", res, 32'h0);
      rchk("status reset", sta, 32'h0);
      rchk("mask reset", `SADC_OFS_IRQ_MASK, 32'h0);
      rdr(5'h14);
      check("unmapped read", rd, 32'h0);
      check("unmapped read response", resp, `SADC_RESP_SLVERR);
      wr(5'h18, 32'h1);
      check("unmapped write", resp, `SADC_RESP_SLVERR);
      $display("test registers done");
      for (int d = 0; d < 6; d++) begin
         wr(cfg, d);
         gap(g);
         gap(g);
         check("tick gap", g, 1 << ((d > 4) ? 4 : d));
      end
      wr(cfg, 32'h4);
      rchk("cfg back", cfg, 32'h4);
      $display("test divider done");
      check("track idle", trk, 1'b1);
      @(posedge clk);
      stby <= 1'b1;
      repeat (5) @(negedge clk);
      check("track standby", trk, 1'b0);
      @(posedge clk);
      stby <= 1'b0;
      $display("test standby done");
      wr(`SADC_OFS_IRQ_MASK, 32'h1);
      level <= 8'hA5;
      pulse();
      rchk("overflow ignored", ctl, 32'h0);
      wr(ctl, 32'h08);
      rchk("busy", ctl, 32'h08);
      conv_end(8'hA5, 32'h10, 1'b1);
      check("dac hold", dac, 8'hA5);
      check("convert span", lo_len, 256);
      $display("test software start done");
      level <= 8'h3C;
      wr(ctl, 32'h0C);
      conv_end(8'h3C, 32'h14, 1'b1);
      check("track span", hi_len, 48);
      check("untracked after", trk, 1'b0);
      wr(ctl, 32'h04);
      rchk("done cleared", ctl, 32'h04);
      $display("test low power software done");
      wr(`SADC_OFS_IRQ_MASK, 32'h0);
      level <= 8'h5A;
      // the busy bit obeys the mode already stored, so select the timer first
      wr(ctl, 32'h05);
      wr(ctl, 32'h0D);
      rchk("write ignored", ctl, 32'h05);
      hi_len = 0;
      pulse();
      conv_end(8'h5A, 32'h15, 1'b0);
      check("timed track span", hi_len, 48);
      $display("test timed start done");
      close_out();
   end

   // the whole sequence needs about 1200 cycles; 20000 cycles, some sixteen times that, is a hang
   initial begin
      #80000;
      err_count++;
      close_out();
   end
endmodule : sadc_ctrl_bench
